// ===== pkg/nvs_pkg.sv
// constants, types and helpers for the protection option loader and backdoor key block
// assumes a byte-wide register port and a byte-wide nonvolatile array read port on one clock
package nvs_pkg;
	localparam int unsigned ADDR_W               = 16;
	localparam int unsigned DATA_W               = 8;
	localparam int unsigned KEY_BYTES            = 8;
	localparam int unsigned LOAD_COUNT           = 10;
	localparam logic [15:0] KEY_BASE_ADDR        = 16'hFFB0;
	localparam logic [15:0] KEY_LAST_ADDR        = 16'hFFB7;
	localparam logic [15:0] NV_PROTECT_ADDR      = 16'hFFBD;
	localparam logic [15:0] NV_OPTION_ADDR       = 16'hFFBF;
	localparam logic [15:0] OPTION_WORKING_ADDR  = 16'h1821;
	localparam logic [15:0] KEY_ACCESS_ADDR      = 16'h1823;
	localparam logic [15:0] PROTECT_WORKING_ADDR = 16'h1824;
	localparam logic [15:0] SEC_STATUS_ADDR      = 16'h1828;
	localparam int unsigned BACKDOOR_KEY_ENABLE_BIT            = 7;
	localparam int unsigned KEY_WR_EN_BIT        = 5;
	localparam int unsigned STAT_SECURED_BIT     = 0;
	localparam int unsigned STAT_UNLOCKED_BIT    = 1;
	localparam int unsigned STAT_KEY_FAIL_BIT    = 2;
	localparam int unsigned STAT_LOADED_BIT      = 3;
	localparam int unsigned STAT_ERASED_BIT      = 4;
	localparam logic [1:0]  SEC_UNSECURED        = 2'h2;
	localparam logic [7:0]  PROTECT_RESET        = 8'hFF;
	localparam logic [7:0]  OPTION_RESET         = 8'hFF;
	localparam logic [7:0]  OPTION_READ_MASK     = 8'hC3;
	localparam logic [7:0]  KEY_ACCESS_RESET     = 8'h00;
	localparam logic [7:0]  KEY_ACCESS_MASK      = 8'h20;
	localparam logic [3:0]  LOAD_INDEX_PROTECT   = 4'h8;
	localparam logic [3:0]  LOAD_INDEX_OPTION    = 4'h9;

	typedef enum logic [1:0] {
		NVS_LD_ISSUE   = 2'b00,
		NVS_LD_CAPTURE = 2'b01,
		NVS_LD_DONE    = 2'b10
	} nvs_load_state_t;

	function automatic logic nvs_is_key_addr(input logic [15:0] addr);
		return (addr >= KEY_BASE_ADDR) && (addr <= KEY_LAST_ADDR);
	endfunction

	function automatic logic [15:0] nvs_load_addr(input logic [3:0] idx);
		logic [15:0] a;
		a = KEY_BASE_ADDR + {12'h000, idx};
		if (idx == LOAD_INDEX_PROTECT) begin
			a = NV_PROTECT_ADDR;
		end else if (idx == LOAD_INDEX_OPTION) begin
			a = NV_OPTION_ADDR;
		end
		return a;
	endfunction
endpackage

// ===== hw/nvs_loader.sv
// reset-time copy of key, protection byte and option byte out of the nonvolatile array
// assumes the array answers a read strobe with data in the next cycle
`timescale 1ns/1ps
`default_nettype none
module nvs_loader (
	input  wire logic                       clk_sys_in,
	input  wire logic                       reset_in,
	output logic                            nv_rd_out,
	output logic [nvs_pkg::ADDR_W-1:0]      nv_addr_out,
	input  wire logic [nvs_pkg::DATA_W-1:0] nv_rdata_in,
	output logic                            load_valid_out,
	output logic [3:0]                      load_index_out,
	output logic [nvs_pkg::DATA_W-1:0]      load_data_out,
	output logic                            load_done_out
);
	import nvs_pkg::*;

	nvs_load_state_t state_q;
	logic [3:0]      idx_q;

	assign nv_rd_out     = (state_q == NVS_LD_ISSUE);
	assign nv_addr_out   = nvs_load_addr(idx_q);
	// done only once the last captured byte has reached its working register
	assign load_done_out = (state_q == NVS_LD_DONE) && !load_valid_out;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_q <= NVS_LD_ISSUE;
			idx_q   <= 4'h0;
		end else begin
			unique case (state_q)
				NVS_LD_ISSUE: begin
					state_q <= NVS_LD_CAPTURE;
				end
				NVS_LD_CAPTURE: begin
					if (idx_q == LOAD_INDEX_OPTION) begin
						state_q <= NVS_LD_DONE;
					end else begin
						idx_q   <= idx_q + 4'h1;
						state_q <= NVS_LD_ISSUE;
					end
				end
				NVS_LD_DONE: begin
					state_q <= NVS_LD_DONE;
				end
				default: begin
					state_q <= NVS_LD_DONE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			load_valid_out <= 1'b0;
			load_index_out <= 4'h0;
			load_data_out  <= 8'h00;
		end else begin
			load_valid_out <= (state_q == NVS_LD_CAPTURE);
			if (state_q == NVS_LD_CAPTURE) begin
				load_index_out <= idx_q;
				load_data_out  <= nv_rdata_in;
			end
		end
	end
endmodule
`default_nettype wire

// ===== hw/nvs_key_cmp.sv
// collects entered backdoor key bytes and compares a full set against the stored key
// assumes entry writes are already qualified by the caller
`timescale 1ns/1ps
`default_nettype none
module nvs_key_cmp #(
	parameter int unsigned KEY_BYTES = nvs_pkg::KEY_BYTES
) (
	input  wire logic                   clk_sys_in,
	input  wire logic                   reset_in,
	input  wire logic                   entry_valid_in,
	input  wire logic [2:0]             entry_index_in,
	input  wire logic [7:0]             entry_data_in,
	input  wire logic [KEY_BYTES*8-1:0] stored_key_in,
	output logic                        match_out,
	output logic                        mismatch_out
);
	import nvs_pkg::*;

	if (KEY_BYTES != 8) begin : g_bad_width
		$error("key width must be eight bytes");
	end

	logic [7:0]           entered_q [KEY_BYTES];
	logic [KEY_BYTES-1:0] mask_q;
	logic                 all_in;
	logic                 same;

	assign all_in = &mask_q;

	always_comb begin
		same = 1'b1;
		for (int i = 0; i < KEY_BYTES; i++) begin
			if (entered_q[i] != stored_key_in[i*8 +: 8]) begin
				same = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			mask_q <= '0;
			for (int i = 0; i < KEY_BYTES; i++) begin
				entered_q[i] <= 8'h00;
			end
		end else begin
			if (all_in) begin
				mask_q <= '0;
			end
			// a byte arriving in the compare cycle still counts
			if (entry_valid_in) begin
				entered_q[entry_index_in] <= entry_data_in;
				mask_q[entry_index_in]    <= 1'b1;
			end
		end
	end

	// every byte must match before the pulse
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			match_out    <= 1'b0;
			mismatch_out <= 1'b0;
		end else begin
			match_out    <= all_in && same;
			mismatch_out <= all_in && !same;
		end
	end
endmodule
`default_nettype wire

// ===== hw/nvs_top.sv
// protection option loader, security state and backdoor key entry
// assumes cpu access qualifiers arrive on the same clock as the register port
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - At every reset the protection and option bytes are copied from the array into working registers that steer protection and security.
// - The eight-byte comparison key is held from the eight array bytes at 0xFFB0 through 0xFFB7.
// - The key can lift security only while the key enable bit reads 1.
// - A key unlock lasts only until the next reset, after which security comes again from the loaded bits.
// - Key bytes are taken only from user code running in secure memory, never from background debug.
// - With the key enable bit at 0 the key is dead and only a blank-checked mass erase lifts security.
// - Security field value 1:0 means unsecured at reset and every other value means secured.
// - While secured, RAM accesses from background debug or non-secure code are blocked.
module nvs_top (
	input  wire logic                       clk_sys_in,
	input  wire logic                       reset_in,
	input  wire logic [nvs_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [nvs_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                       reg_wr_in,
	input  wire logic                       reg_rd_in,
	output logic [nvs_pkg::DATA_W-1:0]      reg_rdata_out,
	input  wire logic                       src_secure_code_in,
	input  wire logic                       src_background_debug_mode_in,
	output logic                            nv_rd_out,
	output logic [nvs_pkg::ADDR_W-1:0]      nv_addr_out,
	input  wire logic [nvs_pkg::DATA_W-1:0] nv_rdata_in,
	input  wire logic                       blank_verified_in,
	input  wire logic                       ram_req_in,
	input  wire logic                       ram_req_debug_in,
	input  wire logic                       ram_req_nonsecure_in,
	output logic                            ram_grant_out,
	output logic                            ram_denied_out,
	output logic                            secured_out,
	output logic [nvs_pkg::DATA_W-1:0]      protect_working_out,
	output logic                            load_done_out
);
	import nvs_pkg::*;

	logic        load_valid;
	logic [3:0]  load_index;
	logic [7:0]  load_data;
	logic        load_done;
	logic        key_match;
	logic        key_mismatch;

	logic [7:0]  protect_working_q;
	logic [7:0]  option_working_q;
	logic [63:0] backdoor_compare_key_q;
	logic [7:0]  key_access_q;
	logic        key_unlocked_q;
	logic        key_failed_q;
	logic        erase_unlocked_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;

	logic        backdoor_key_enable;
	logic        security_state_high;
	logic        security_state_low;
	logic        field_unsecured;
	logic        secured;
	logic        key_entry_ok;
	logic        key_entry_wr;
	logic        ram_unsafe_src;

	nvs_loader u_loader (
		.clk_sys_in     (clk_sys_in),
		.reset_in       (reset_in),
		.nv_rd_out      (nv_rd_out),
		.nv_addr_out    (nv_addr_out),
		.nv_rdata_in    (nv_rdata_in),
		.load_valid_out (load_valid),
		.load_index_out (load_index),
		.load_data_out  (load_data),
		.load_done_out  (load_done)
	);

	// working copies filled from the array after each reset
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			protect_working_q <= PROTECT_RESET;
			option_working_q  <= OPTION_RESET;
		end else if (load_valid && load_index == LOAD_INDEX_PROTECT) begin
			protect_working_q <= load_data;
		end else if (load_valid && load_index == LOAD_INDEX_OPTION) begin
			option_working_q  <= load_data;
		end else if (reg_wr_in && load_done && reg_addr_in == PROTECT_WORKING_ADDR) begin
			protect_working_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			backdoor_compare_key_q <= 64'h0;
		end else if (load_valid && load_index < LOAD_INDEX_PROTECT) begin
			backdoor_compare_key_q[load_index[2:0]*8 +: 8] <= load_data;
		end
	end

	assign backdoor_key_enable = option_working_q[BACKDOOR_KEY_ENABLE_BIT];
	assign security_state_high = option_working_q[1];
	assign security_state_low  = option_working_q[0];
	assign field_unsecured     = {security_state_high, security_state_low} == SEC_UNSECURED;

	// secured until the load finishes, then from the field unless unlocked
	assign secured = !load_done || !(field_unsecured || key_unlocked_q || erase_unlocked_q);

	// key entry only from secure user code, never from debug
	assign key_entry_ok = load_done && secured && backdoor_key_enable && !key_failed_q
		&& key_access_q[KEY_WR_EN_BIT]
		&& src_secure_code_in && !src_background_debug_mode_in;
	assign key_entry_wr = reg_wr_in && nvs_is_key_addr(reg_addr_in) && key_entry_ok;

	nvs_key_cmp #(
		.KEY_BYTES (KEY_BYTES)
	) u_key_cmp (
		.clk_sys_in     (clk_sys_in),
		.reset_in       (reset_in),
		.entry_valid_in (key_entry_wr),
		.entry_index_in (reg_addr_in[2:0]),
		.entry_data_in  (reg_wdata_in),
		.stored_key_in  (backdoor_compare_key_q),
		.match_out      (key_match),
		.mismatch_out   (key_mismatch)
	);

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			key_access_q <= KEY_ACCESS_RESET;
		end else if (reg_wr_in && reg_addr_in == KEY_ACCESS_ADDR) begin
			key_access_q <= reg_wdata_in & KEY_ACCESS_MASK;
		end
	end

	// unlock state lives only until the next reset
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			key_unlocked_q <= 1'b0;
			key_failed_q   <= 1'b0;
		end else begin
			if (key_match && backdoor_key_enable && !key_failed_q) begin
				key_unlocked_q <= 1'b1;
			end
			if (key_mismatch) begin
				key_failed_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			erase_unlocked_q <= 1'b0;
		end else if (blank_verified_in && load_done) begin
			erase_unlocked_q <= 1'b1;
		end
	end

	// key and array bytes read back only while unsecured
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd_in && load_done) begin
			if (reg_addr_in == PROTECT_WORKING_ADDR) begin
				rdata_d = protect_working_q;
			end else if (reg_addr_in == OPTION_WORKING_ADDR) begin
				rdata_d = option_working_q & OPTION_READ_MASK;
			end else if (reg_addr_in == KEY_ACCESS_ADDR) begin
				rdata_d = key_access_q;
			end else if (reg_addr_in == SEC_STATUS_ADDR) begin
				rdata_d[STAT_SECURED_BIT]  = secured;
				rdata_d[STAT_UNLOCKED_BIT] = key_unlocked_q;
				rdata_d[STAT_KEY_FAIL_BIT] = key_failed_q;
				rdata_d[STAT_LOADED_BIT]   = load_done;
				rdata_d[STAT_ERASED_BIT]   = erase_unlocked_q;
			end else if (!secured && nvs_is_key_addr(reg_addr_in)) begin
				rdata_d = backdoor_compare_key_q[reg_addr_in[2:0]*8 +: 8];
			end else if (!secured && reg_addr_in == NV_PROTECT_ADDR) begin
				rdata_d = protect_working_q;
			end else if (!secured && reg_addr_in == NV_OPTION_ADDR) begin
				rdata_d = option_working_q;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign ram_unsafe_src = ram_req_debug_in || ram_req_nonsecure_in;
	assign ram_grant_out  = ram_req_in && !(secured && ram_unsafe_src);
	assign ram_denied_out = ram_req_in && secured && ram_unsafe_src;

	assign reg_rdata_out       = rdata_q;
	assign secured_out         = secured;
	assign protect_working_out = protect_working_q;
	assign load_done_out       = load_done;

	// helper: count load cycles since reset release
	logic [4:0] load_cycles_q;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			load_cycles_q <= 5'h00;
		end else if (!load_done) begin
			load_cycles_q <= load_cycles_q + 5'h01;
		end
	end

	load_finishes_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		load_cycles_q <= 5'd21)
		else $error("option load did not finish in twenty-one cycles");

	option_copied_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(load_valid && load_index == LOAD_INDEX_OPTION) |=> (option_working_q == $past(load_data)))
		else $error("option working copy not taken from array");

	protect_copied_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(load_valid && load_index == LOAD_INDEX_PROTECT) |=> (protect_working_q == $past(load_data)))
		else $error("protect working copy not taken from array");

	key_addr_walk_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(nv_rd_out && !load_done && load_cycles_q < 5'd16) |-> (nv_addr_out >= KEY_BASE_ADDR && nv_addr_out <= KEY_LAST_ADDR))
		else $error("key load address out of key range");

	key_needs_enable_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$rose(key_unlocked_q) |-> $past(backdoor_key_enable))
		else $error("key unlock with key enable clear");

	unlock_clears_a: assert property (@(posedge clk_sys_in)
		reset_in |=> !key_unlocked_q && !erase_unlocked_q)
		else $error("unlock survived reset");

	debug_no_entry_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(src_background_debug_mode_in || !src_secure_code_in) |-> !key_entry_wr)
		else $error("key entry accepted from unsafe source");

	disabled_key_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(!backdoor_key_enable && !key_unlocked_q) |=> !key_unlocked_q)
		else $error("disabled key lifted security");

	field_decode_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(load_done && !key_unlocked_q && !erase_unlocked_q)
		|-> (secured == (option_working_q[1:0] != SEC_UNSECURED)))
		else $error("security field decoded wrongly");

	mismatch_locks_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		key_mismatch |=> key_failed_q ##1 (key_failed_q && !$rose(key_unlocked_q)))
		else $error("mismatch did not lock key");

	ram_blocked_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(secured && ram_req_in && (ram_req_debug_in || ram_req_nonsecure_in)) |-> (!ram_grant_out && ram_denied_out))
		else $error("unsafe ram access passed while secured");

	read_one_cycle_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(!reg_rd_in) |=> (reg_rdata_out == 8'h00))
		else $error("read data outside answer cycle");
endmodule
`default_nettype wire

// ===== dv/nvs_tb_top.sv
// self-checking bench for the option loader, security state and backdoor key entry
// assumes nvs_pkg is compiled first; the bench plays the nonvolatile array and the cpu
`timescale 1ns/1ps
`default_nettype none
module nvs_tb_top;
	import nvs_pkg::*;
	logic              clk_sys_in = 1'b0;
	logic              reset_in = 1'b1;
	logic [15:0]       reg_addr_in = 16'h0000;
	logic [7:0]        reg_wdata_in = 8'h00;
	logic              reg_wr_in = 1'b0;
	logic              reg_rd_in = 1'b0;
	logic [7:0]        reg_rdata_out;
	logic              src_secure_code_in = 1'b1;
	logic              src_background_debug_mode_in = 1'b0;
	logic              nv_rd_out;
	logic [15:0]       nv_addr_out;
	logic [7:0]        nv_rdata_in = 8'h00;
	logic              blank_verified_in = 1'b0;
	logic              ram_req_in = 1'b0;
	logic              ram_req_debug_in = 1'b0;
	logic              ram_req_nonsecure_in = 1'b0;
	logic              ram_grant_out;
	logic              ram_denied_out;
	logic              secured_out;
	logic [7:0]        protect_working_out;
	logic              load_done_out;
	logic [7:0]        mem [logic [15:0]];
	logic [7:0]        key_v [8];
	logic [7:0]        opt_v;
	logic [7:0]        d;
	logic [7:0]        p;
	bit                unlocked;
	bit                erased;
	bit                failed;
	int                num_errors = 0;
	int                compares = 0;
	int                cyc = 0;

	nvs_top dut (
		.clk_sys_in                   (clk_sys_in),
		.reset_in                     (reset_in),
		.reg_addr_in                  (reg_addr_in),
		.reg_wdata_in                 (reg_wdata_in),
		.reg_wr_in                    (reg_wr_in),
		.reg_rd_in                    (reg_rd_in),
		.reg_rdata_out                (reg_rdata_out),
		.src_secure_code_in           (src_secure_code_in),
		.src_background_debug_mode_in (src_background_debug_mode_in),
		.nv_rd_out                    (nv_rd_out),
		.nv_addr_out                  (nv_addr_out),
		.nv_rdata_in                  (nv_rdata_in),
		.blank_verified_in            (blank_verified_in),
		.ram_req_in                   (ram_req_in),
		.ram_req_debug_in             (ram_req_debug_in),
		.ram_req_nonsecure_in         (ram_req_nonsecure_in),
		.ram_grant_out                (ram_grant_out),
		.ram_denied_out               (ram_denied_out),
		.secured_out                  (secured_out),
		.protect_working_out          (protect_working_out),
		.load_done_out                (load_done_out)
	);

	always #5 clk_sys_in = ~clk_sys_in;

	// array answers one cycle after a read strobe, noise otherwise
	always @(posedge clk_sys_in) begin
		if (nv_rd_out === 1'b1) begin
			nv_rdata_in <= mem[nv_addr_out];
		end else begin
			nv_rdata_in <= 8'($urandom);
		end
	end

	task automatic results();
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			results();
		end
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic exp_sec();
		return !(opt_v[1:0] == SEC_UNSECURED || unlocked || erased);
	endfunction

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask

	task automatic boot(input logic [7:0] opt, input logic [7:0] prot);
		int n;
		opt_v = opt;
		unlocked = 0;
		erased = 0;
		failed = 0;
		mem[NV_OPTION_ADDR] = opt;
		mem[NV_PROTECT_ADDR] = prot;
		for (n = 0; n < 8; n++) begin
			key_v[n] = 8'($urandom);
			mem[KEY_BASE_ADDR + 16'(n)] = key_v[n];
		end
		@(posedge clk_sys_in);
		reset_in <= 1'b1;
		repeat (16) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		#1;
		chk("secured_out in reset", {7'h00, secured_out}, 8'h01);
		chk("load_done_out in reset", {7'h00, load_done_out}, 8'h00);
		chk("protect_working_out in reset", protect_working_out, PROTECT_RESET);
		n = 0;
		while (load_done_out !== 1'b1 && n < 100) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		chk("load cycles", 8'(n), 8'(2 * LOAD_COUNT + 1));
		chk("load_done_out", {7'h00, load_done_out}, 8'h01);
		chk("protect_working_out", protect_working_out, prot);
		chk("secured_out after load", {7'h00, secured_out}, {7'h00, exp_sec()});
	endtask

	// eight key writes in descending order; a bad key flips byte 0, written last
	task automatic key(input bit good, input bit sec_code, input bit dbg);
		logic [7:0] b;
		bit         q;
		int         i;
		@(posedge clk_sys_in);
		src_secure_code_in <= sec_code;
		src_background_debug_mode_in <= dbg;
		wr(KEY_ACCESS_ADDR, 8'h20);
		for (i = 7; i >= 0; i--) begin
			b = good ? key_v[i] : ~key_v[i];
			wr(KEY_BASE_ADDR + 16'(i), (i == 0) ? b : key_v[i]);
		end
		repeat (4) @(posedge clk_sys_in);
		#1;
		q = sec_code && !dbg && opt_v[BACKDOOR_KEY_ENABLE_BIT] && !failed && exp_sec();
		if (q && good) begin
			unlocked = 1;
		end else if (q) begin
			failed = 1;
		end
		chk("secured_out after key", {7'h00, secured_out}, {7'h00, exp_sec()});
	endtask

	task automatic ram(input bit dbg, input bit ns);
		logic g;
		@(posedge clk_sys_in);
		ram_req_in <= 1'b1;
		ram_req_debug_in <= dbg;
		ram_req_nonsecure_in <= ns;
		#1;
		g = !((dbg || ns) && exp_sec());
		chk("ram_grant_out", {7'h00, ram_grant_out}, {7'h00, g});
		chk("ram_denied_out", {7'h00, ram_denied_out}, {7'h00, !g});
		@(posedge clk_sys_in);
		ram_req_in <= 1'b0;
	endtask

	initial begin
		void'($urandom(32'hFEE7));
		boot(8'h83, 8'($urandom));
		rd(OPTION_WORKING_ADDR, d);
		chk("option_working", d, 8'h83 & OPTION_READ_MASK);
		wr(OPTION_WORKING_ADDR, 8'h7C);
		rd(OPTION_WORKING_ADDR, d);
		chk("option_working read only", d, 8'h83 & OPTION_READ_MASK);
		rd(16'h1822, d);
		chk("unmapped read", d, 8'h00);
		rd(KEY_BASE_ADDR + 16'h0003, d);
		chk("key byte while secured", d, 8'h00);
		ram(1'b1, 1'b0);
		ram(1'b0, 1'b1);
		ram(1'b0, 1'b0);
		p = 8'($urandom);
		wr(PROTECT_WORKING_ADDR, p);
		rd(PROTECT_WORKING_ADDR, d);
		chk("protect_working readback", d, p);
		chk("protect_working_out", protect_working_out, p);
		key(1'b1, 1'b1, 1'b1);
		key(1'b1, 1'b0, 1'b0);
		key(1'b0, 1'b1, 1'b0);
		key(1'b1, 1'b1, 1'b0);
		rd(SEC_STATUS_ADDR, d);
		chk("status after bad key", d, {3'b000, erased, 1'b1, failed, unlocked, exp_sec()});
		rd(KEY_ACCESS_ADDR, d);
		chk("key access readback", d, 8'h20);
		boot(8'h83, 8'($urandom));
		key(1'b1, 1'b1, 1'b0);
		rd(SEC_STATUS_ADDR, d);
		chk("status after good key", d, {3'b000, erased, 1'b1, failed, unlocked, exp_sec()});
		for (int i = 0; i < 8; i++) begin
			rd(KEY_BASE_ADDR + 16'(i), d);
			chk("key byte unsecured", d, key_v[i]);
		end
		ram(1'b1, 1'b0);
		ram(1'b0, 1'b1);
		boot(8'h83, 8'($urandom));
		boot(8'h03, 8'($urandom));
		key(1'b1, 1'b1, 1'b0);
		@(posedge clk_sys_in);
		blank_verified_in <= 1'b1;
		@(posedge clk_sys_in);
		blank_verified_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		erased = 1;
		chk("secured_out after erase", {7'h00, secured_out}, {7'h00, exp_sec()});
		for (int s = 0; s < 4; s++) begin
			boot({2'b10, 4'h0, 2'(s)}, 8'($urandom));
		end
		results();
	end
endmodule
`default_nettype wire
